// ==== hdl/p0fc_regs.sv ====
`timescale 1ns/1ns
`default_nettype none
module p0fc_regs (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Host register access
    input wire logic [p0fc_pkg::ADDR_W-1:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [p0fc_pkg::DATA_W-1:0] reg_wdata_in,
    output logic [p0fc_pkg::DATA_W-1:0] reg_rdata_out,
    output logic reg_ack_out,
    // Straps and loader
    input wire logic backpressure_strap_in,
    input wire logic full_duplex_pause_strap_in,
    input wire logic manual_pause_strap_in,
    input wire logic strap_reload_in,
    input wire logic mac_mode_in,
    // Port state
    input wire logic port_half_duplex_in,
    input wire logic vphy_autoneg_en_in,
    input wire logic an_rx_pause_in,
    input wire logic an_tx_pause_in,
    // Port flow control
    output logic backpressure_enable_out,
    output logic rx_pause_enable_out,
    output logic tx_pause_enable_out,
    // Fabric CSR access
    output logic fabric_req_out,
    output logic fabric_read_out,
    output logic [p0fc_pkg::FADDR_W-1:0] fabric_addr_out,
    output logic [p0fc_pkg::DATA_W-1:0] fabric_wdata_out,
    input wire logic fabric_ack_in,
    input wire logic [p0fc_pkg::DATA_W-1:0] fabric_rdata_in
);

    p0fc_pkg::p0fc_ctl_t ctl_q;
    p0fc_pkg::p0fc_stat_t stat_q;
    p0fc_pkg::p0fc_stat_t stat_d;
    p0fc_pkg::p0fc_fab_t fab_q;
    logic init_q;
    logic load_defaults;
    logic manual_path;
    logic busy_q;
    logic rnw_q;
    logic [p0fc_pkg::FADDR_W-1:0] caddr_q;
    logic [p0fc_pkg::DATA_W-1:0] wdata_q;
    logic [p0fc_pkg::DATA_W-1:0] fdata_q;
    logic [p0fc_pkg::DATA_W-1:0] rdata_q;
    logic ack_q;
    logic req_q;
    logic wr_pause;
    logic wr_cmd;
    logic wr_data;
    logic start;
    logic [p0fc_pkg::PAUSE_W-1:0] pause_word;

    // Straps are taken on the first edge after release, then on each reload
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            init_q <= 1'h0;
        end
        else
        begin
            init_q <= 1'h1;
        end
    end

    assign load_defaults = !init_q || strap_reload_in;
    assign wr_pause = reg_wr_in && (reg_addr_in == p0fc_pkg::OFS_PAUSE);
    // Command and data are frozen while an access is in flight
    assign wr_cmd = reg_wr_in && (reg_addr_in == p0fc_pkg::OFS_CMD) && !busy_q;
    assign wr_data = reg_wr_in && (reg_addr_in == p0fc_pkg::OFS_DATA) && !busy_q;
    assign start = wr_cmd && reg_wdata_in[p0fc_pkg::CMD_BUSY];

    // Writable pause fields; loader beats a host write in the same cycle.
    // Only this register is touched, advertisement fields live elsewhere.
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            ctl_q <= '0;
        end
        else if (load_defaults)
        begin
            ctl_q.bp <= backpressure_strap_in;
            ctl_q.man_rx <= full_duplex_pause_strap_in;
            ctl_q.man_tx <= full_duplex_pause_strap_in;
            ctl_q.man_sel <= mac_mode_in ? p0fc_pkg::MAC_SEL_DEFAULT : manual_pause_strap_in;
        end
        else if (wr_pause)
        begin
            ctl_q.bp <= reg_wdata_in[p0fc_pkg::BIT_BP];
            ctl_q.man_rx <= reg_wdata_in[p0fc_pkg::BIT_MAN_RX];
            ctl_q.man_tx <= reg_wdata_in[p0fc_pkg::BIT_MAN_TX];
            ctl_q.man_sel <= mac_mode_in ? p0fc_pkg::MAC_SEL_DEFAULT
                : reg_wdata_in[p0fc_pkg::BIT_MAN_SEL];
        end
        else if (mac_mode_in)
        begin
            ctl_q.man_sel <= p0fc_pkg::MAC_SEL_DEFAULT;
        end
    end

    // Full-duplex pause has no meaning on a half-duplex link
    assign manual_path = ctl_q.man_sel || !vphy_autoneg_en_in;
    always_comb
    begin
        stat_d.dup = port_half_duplex_in;
        stat_d.rx = !port_half_duplex_in
            && (manual_path ? ctl_q.man_rx : an_rx_pause_in);
        stat_d.tx = !port_half_duplex_in
            && (manual_path ? ctl_q.man_tx : an_tx_pause_in);
    end

    // Status follows the strap-driven port state every cycle
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            stat_q <= '0;
        end
        else
        begin
            stat_q <= stat_d;
        end
    end

    assign backpressure_enable_out = ctl_q.bp;
    assign rx_pause_enable_out = stat_q.rx;
    assign tx_pause_enable_out = stat_q.tx;

    // Command register fields
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rnw_q <= 1'h0;
            caddr_q <= '0;
        end
        else if (wr_cmd)
        begin
            rnw_q <= reg_wdata_in[p0fc_pkg::CMD_DIR];
            caddr_q <= reg_wdata_in[p0fc_pkg::FADDR_W-1:0];
        end
    end

    // Host-written data, kept apart from fabric read data
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            wdata_q <= p0fc_pkg::DATA_RESET;
        end
        else if (wr_data)
        begin
            wdata_q <= reg_wdata_in;
        end
    end

    // Fabric access sequencer
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            fab_q <= p0fc_pkg::FAB_IDLE;
            busy_q <= 1'h0;
            req_q <= 1'h0;
            fdata_q <= p0fc_pkg::DATA_RESET;
        end
        else
        begin
            case (fab_q)
                p0fc_pkg::FAB_IDLE:
                begin
                    if (start)
                    begin
                        fab_q <= p0fc_pkg::FAB_WAIT;
                        busy_q <= 1'h1;
                        req_q <= 1'h1;
                    end
                end
                p0fc_pkg::FAB_WAIT:
                begin
                    if (fabric_ack_in)
                    begin
                        fab_q <= p0fc_pkg::FAB_IDLE;
                        busy_q <= 1'h0;
                        req_q <= 1'h0;
                        if (rnw_q == p0fc_pkg::DIR_READ)
                        begin
                            fdata_q <= fabric_rdata_in;
                        end
                    end
                end
                default:
                begin
                    fab_q <= p0fc_pkg::FAB_IDLE;
                    busy_q <= 1'h0;
                    req_q <= 1'h0;
                end
            endcase
        end
    end

    assign fabric_req_out = req_q;
    assign fabric_read_out = rnw_q;
    assign fabric_addr_out = caddr_q;
    assign fabric_wdata_out = wdata_q;

    assign pause_word = {ctl_q.bp, stat_q.dup, stat_q.rx, stat_q.tx,
        ctl_q.man_rx, ctl_q.man_tx, ctl_q.man_sel};

    // Read data is registered; unmapped offsets answer zero
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            rdata_q <= '0;
            ack_q <= 1'h0;
        end
        else
        begin
            ack_q <= reg_rd_in || reg_wr_in;
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    p0fc_pkg::OFS_PAUSE: rdata_q <= p0fc_pkg::DATA_W'(pause_word);
                    p0fc_pkg::OFS_DATA: rdata_q <= rnw_q ? fdata_q : wdata_q;
                    p0fc_pkg::OFS_CMD: rdata_q <= {busy_q, rnw_q, 14'h0000, caddr_q};
                    default: rdata_q <= '0;
                endcase
            end
        end
    end

    assign reg_rdata_out = rdata_q;
    assign reg_ack_out = ack_q;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!reset_n_in);

    reserved_zero_a: assert property (
        reg_rd_in && reg_addr_in == p0fc_pkg::OFS_PAUSE
        |=> reg_rdata_out[p0fc_pkg::DATA_W-1:p0fc_pkg::PAUSE_W] == '0)
        else $error("pause register reserved bits not zero");

    bp_write_a: assert property (
        wr_pause && !load_defaults
        |=> backpressure_enable_out == $past(reg_wdata_in[p0fc_pkg::BIT_BP]))
        else $error("backpressure enable did not take write");

    dup_read_a: assert property (
        init_q && $past(init_q) && reg_rd_in && reg_addr_in == p0fc_pkg::OFS_PAUSE
        |=> reg_rdata_out[p0fc_pkg::BIT_DUP] == $past(port_half_duplex_in, 2))
        else $error("duplex readback wrong");

    rx_auto_a: assert property (
        !port_half_duplex_in && vphy_autoneg_en_in && !ctl_q.man_sel
        |=> rx_pause_enable_out == $past(an_rx_pause_in)
            && tx_pause_enable_out == $past(an_tx_pause_in))
        else $error("negotiated pause not applied");

    tx_manual_a: assert property (
        !port_half_duplex_in && ctl_q.man_sel
        |=> tx_pause_enable_out == $past(ctl_q.man_tx))
        else $error("manual transmit pause not applied");

    rx_manual_a: assert property (
        !port_half_duplex_in && !vphy_autoneg_en_in
        |=> rx_pause_enable_out == $past(ctl_q.man_rx))
        else $error("manual receive pause not applied");

    half_nopause_a: assert property (
        port_half_duplex_in |=> !rx_pause_enable_out && !tx_pause_enable_out)
        else $error("pause active in half duplex");

    mac_forced_a: assert property (
        mac_mode_in |=> ctl_q.man_sel)
        else $error("manual select not forced in MAC mode");

    strap_load_a: assert property (
        strap_reload_in
        |=> backpressure_enable_out == $past(backpressure_strap_in)
            && ctl_q.man_rx == $past(full_duplex_pause_strap_in))
        else $error("strap reload not applied");

    data_back_a: assert property (
        reg_rd_in && reg_addr_in == p0fc_pkg::OFS_DATA && !rnw_q
        |=> reg_rdata_out == $past(wdata_q))
        else $error("data readback not last write");

    busy_hold_a: assert property (
        busy_q && !fabric_ack_in |=> busy_q && fabric_req_out)
        else $error("busy dropped before completion");

    start_dir_a: assert property (
        start && !busy_q
        |=> fabric_req_out && fabric_read_out == $past(reg_wdata_in[p0fc_pkg::CMD_DIR]))
        else $error("access start or direction wrong");

    fab_read_a: assert property (
        busy_q && fabric_ack_in && rnw_q |=> fdata_q == $past(fabric_rdata_in) && !busy_q)
        else $error("fabric read data not captured");

    man_write_a: assert property (
        wr_pause && !load_defaults
        |=> ctl_q.man_rx == $past(reg_wdata_in[p0fc_pkg::BIT_MAN_RX])
            && ctl_q.man_tx == $past(reg_wdata_in[p0fc_pkg::BIT_MAN_TX]))
        else $error("manual pause enables did not take write");

    mac_readback_a: assert property (
        init_q && mac_mode_in && $past(mac_mode_in)
            && reg_rd_in && reg_addr_in == p0fc_pkg::OFS_PAUSE
        |=> reg_rdata_out[p0fc_pkg::BIT_MAN_SEL])
        else $error("manual select not read-only high in MAC mode");

    strap_sel_a: assert property (
        strap_reload_in
        |=> ctl_q.man_sel == ($past(mac_mode_in) || $past(manual_pause_strap_in)))
        else $error("manual select reload wrong");

    data_write_a: assert property (
        reg_wr_in && reg_addr_in == p0fc_pkg::OFS_DATA && !busy_q
        |=> fabric_wdata_out == $past(reg_wdata_in))
        else $error("data register did not take write");

    busy_refuse_a: assert property (
        busy_q && reg_wr_in
        |=> fabric_wdata_out == $past(fabric_wdata_out)
            && fabric_addr_out == $past(fabric_addr_out))
        else $error("command or data changed while busy");

    manual_write_c: cover property (wr_pause ##1 reg_ack_out);
    fabric_read_c: cover property (start ##[1:20] (busy_q && fabric_ack_in && rnw_q));
    mac_reload_c: cover property (mac_mode_in && strap_reload_in);
    auto_pause_c: cover property (!ctl_q.man_sel && vphy_autoneg_en_in ##1 rx_pause_enable_out);

endmodule
`default_nettype wire

// ==== hdl/p0fc_pkg.sv ====
// Overview of operation
// - Bit 6 enables half-duplex backpressure on port 0.
// - Bit 5 reads resolved duplex: 0 full, 1 half.
// - Bit 4 reads whether receive pause is currently enabled.
// - Bit 3 reads whether transmit pause is currently enabled.
// - Bit 2 gates pause detection when manual or negotiation is off.
// - Bit 1 gates pause generation when manual or negotiation is off.
// - Select clear and negotiation on: negotiated result used, manual bits ignored.
// - Select set: manual pause bits decide full-duplex flow control.
// - MAC mode forces the manual select bit high.
// - Writable bits default from straps; loader rewrite updates them.
// - Status bits derive from straps and follow loader rewrites.
// - Manual select is read-only in MAC mode.
// - MAC mode: loader leaves manual select alone, default 1.
// - Writing this register leaves virtual PHY advertisement untouched.
// - 32-bit data register carries fabric CSR value, resets zero.
// - Data read gives fabric data if direction read, else last write.
// - Command bit 30 selects direction: 0 write, 1 read.
// - Command bit 31 starts access, stays set until done.
`default_nettype none
package p0fc_pkg;
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;
    localparam int FADDR_W = 16;
    localparam int PAUSE_W = 7;
    localparam logic [ADDR_W-1:0] OFS_PAUSE = 12'h1A8;
    localparam logic [ADDR_W-1:0] OFS_DATA = 12'h1AC;
    localparam logic [ADDR_W-1:0] OFS_CMD = 12'h1B0;
    localparam int BIT_BP = 6;
    localparam int BIT_DUP = 5;
    localparam int BIT_CUR_RX = 4;
    localparam int BIT_CUR_TX = 3;
    localparam int BIT_MAN_RX = 2;
    localparam int BIT_MAN_TX = 1;
    localparam int BIT_MAN_SEL = 0;
    localparam int CMD_BUSY = 31;
    localparam int CMD_DIR = 30;
    localparam logic [DATA_W-1:0] DATA_RESET = 32'h0000_0000;
    localparam logic MAC_SEL_DEFAULT = 1'h1;
    localparam logic DIR_READ = 1'h1;

    typedef struct packed {
        logic bp;
        logic man_rx;
        logic man_tx;
        logic man_sel;
    } p0fc_ctl_t;

    typedef struct packed {
        logic dup;
        logic rx;
        logic tx;
    } p0fc_stat_t;

    typedef enum logic {FAB_IDLE, FAB_WAIT} p0fc_fab_t;
endpackage
`default_nettype wire

// ==== tb/p0fc_fabric_model.sv ====
`timescale 1ns/1ns
`default_nettype none
module p0fc_fabric_model (
    // Clock and reset
    input wire logic core_clk_in,
    input wire logic reset_n_in,
    // Fabric access
    input wire logic req_in,
    input wire logic read_in,
    input wire logic [15:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic [3:0] wait_in,
    output logic ack_out,
    output logic [31:0] rdata_out,
    output logic [31:0] last_wr_out
);
    logic [3:0] cnt_q;
    always_ff @(posedge core_clk_in or negedge reset_n_in)
    begin
        if (!reset_n_in)
        begin
            cnt_q <= 4'h0;
            ack_out <= 1'b0;
            rdata_out <= 32'h0000_0000;
            last_wr_out <= 32'h0000_0000;
        end
        else
        begin
            ack_out <= 1'b0;
            // Stale data toggles so a late capture cannot pass
            rdata_out <= ~rdata_out;
            if (!req_in || ack_out)
                cnt_q <= 4'h0;
            else if (cnt_q != wait_in)
                cnt_q <= cnt_q + 4'h1;
            else
            begin
                ack_out <= 1'b1;
                rdata_out <= read_in ? {~addr_in, addr_in} : ~rdata_out;
                if (!read_in)
                    last_wr_out <= wdata_in;
            end
        end
    end
endmodule
`default_nettype wire

// ==== tb/p0fc_regs_tb.sv ====
`timescale 1ns/1ns
`default_nettype none
module p0fc_regs_tb;
    logic core_clk_in, reset_n_in, wr, rdn, ack, bps, fds, mps, rel, mac, half, ane, anr, ant;
    logic bpo, rxo, txo, freq, frd, fack;
    logic [11:0] addr;
    logic [15:0] fadr;
    logic [31:0] wd, rdo, fwd, frdata, last_wr, rd, d, c;
    logic [3:0] fab_wait;
    p0fc_pkg::p0fc_ctl_t ctl;
    int errors, checked, seed, i;
    p0fc_regs u_p0fc_regs (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .reg_addr_in(addr), .reg_wr_in(wr), .reg_rd_in(rdn), .reg_wdata_in(wd),
        .reg_rdata_out(rdo), .reg_ack_out(ack), .backpressure_strap_in(bps),
        .full_duplex_pause_strap_in(fds), .manual_pause_strap_in(mps), .strap_reload_in(rel),
        .mac_mode_in(mac), .port_half_duplex_in(half), .vphy_autoneg_en_in(ane),
        .an_rx_pause_in(anr), .an_tx_pause_in(ant), .backpressure_enable_out(bpo),
        .rx_pause_enable_out(rxo), .tx_pause_enable_out(txo), .fabric_req_out(freq),
        .fabric_read_out(frd), .fabric_addr_out(fadr), .fabric_wdata_out(fwd),
        .fabric_ack_in(fack), .fabric_rdata_in(frdata));
    p0fc_fabric_model u_p0fc_fabric_model (.core_clk_in(core_clk_in), .reset_n_in(reset_n_in),
        .req_in(freq), .read_in(frd), .addr_in(fadr), .wdata_in(fwd), .wait_in(fab_wait),
        .ack_out(fack), .rdata_out(frdata), .last_wr_out(last_wr));
    task automatic summarize();
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic fail(input string msg);
        $display("BAD %0t %s", $time, msg);
        errors++;
    endtask
    task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
        checked++;
        if (got !== exp)
            fail($sformatf("%s got %h exp %h", what, got, exp));
    endtask
    // Entered at a falling edge; spacer cycle keeps strobes apart
    task automatic access(input logic w, input logic [11:0] a, input logic [31:0] v);
        wr = w;
        rdn = !w;
        addr = a;
        wd = v;
        @(negedge core_clk_in);
        wr = 1'b0;
        rdn = 1'b0;
        cmp({31'h0, ack}, 32'h1, "ack");
        rd = rdo;
        @(negedge core_clk_in);
    endtask
    function automatic logic [31:0] exp_pause(input p0fc_pkg::p0fc_ctl_t k);
        logic m;
        m = k.man_sel || !ane;
        exp_pause = {25'h0, k.bp, half, !half && (m ? k.man_rx : anr),
            !half && (m ? k.man_tx : ant), k.man_rx, k.man_tx, k.man_sel};
    endfunction
    task automatic chk_pause();
        logic [31:0] e;
        repeat (3) @(negedge core_clk_in);
        e = exp_pause(ctl);
        access(1'b0, p0fc_pkg::OFS_PAUSE, 32'h0);
        cmp(rd, e, "pause");
        cmp({29'h0, bpo, rxo, txo}, {29'h0, e[6], e[4], e[3]}, "outs");
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        do
        begin
            access(1'b0, p0fc_pkg::OFS_CMD, 32'h0);
            n++;
        end
        while (rd[31] !== 1'b0 && n < 40);
        if (rd[31] !== 1'b0)
        begin
            fail("busy stuck");
            summarize();
        end
    endtask
    initial
    begin
        core_clk_in = 1'b0;
        forever #25 core_clk_in = ~core_clk_in;
    end
    initial
    begin
        repeat (20000) @(posedge core_clk_in);
        fail("timeout");
        summarize();
    end
    initial
    begin
        seed = 86;
        errors = 0;
        checked = 0;
        {wr, rdn, rel, addr, wd, fab_wait} = 51'h0;
        {bps, fds, mps, mac, half, ane, anr, ant} = 8'($random(seed));
        reset_n_in = 1'b0;
        repeat (2) @(negedge core_clk_in);
        reset_n_in = 1'b1;
        ctl = '{bps, fds, fds, mac | mps};
        chk_pause();
        access(1'b0, p0fc_pkg::OFS_DATA, 32'h0);
        cmp(rd, p0fc_pkg::DATA_RESET, "data reset");
        for (i = 0; i < 16; i++)
        begin
            {mac, half, ane, anr, ant} = 5'($random(seed));
            d = $random(seed);
            if (i == 0)
                {mac, half, d} = {2'h2, 32'hFFFF_FF80};
            @(negedge core_clk_in);
            access(1'b1, p0fc_pkg::OFS_PAUSE, d);
            ctl = '{d[6], d[2], d[1], mac | d[0]};
            chk_pause();
        end
        for (i = 0; i < 3; i++)
        begin
            {bps, fds, mps, mac} = (i == 0) ? 4'h1 : 4'($random(seed));
            rel = 1'b1;
            @(negedge core_clk_in);
            rel = 1'b0;
            ctl = '{bps, fds, fds, mac | mps};
            chk_pause();
        end
        for (i = 0; i < 6; i++)
        begin
            d = $random(seed);
            fab_wait = 4'($random(seed)) | 4'h3;
            c = {1'b1, i[0], 14'h0, d[15:0]};
            access(1'b1, p0fc_pkg::OFS_DATA, d);
            access(1'b1, p0fc_pkg::OFS_CMD, c);
            // Request is looked at before the shortest fabric wait can end it
            cmp({freq, frd, fadr}, {1'b1, c[30], d[15:0]}, "fab req");
            access(1'b1, p0fc_pkg::OFS_DATA, ~d);
            access(1'b0, p0fc_pkg::OFS_CMD, 32'h0);
            cmp(rd, c, "busy");
            cmp(fwd, d, "fab wdata");
            wait_idle();
            access(1'b0, p0fc_pkg::OFS_DATA, 32'h0);
            cmp(rd, i[0] ? {~d[15:0], d[15:0]} : d, "data");
            if (!i[0])
                cmp(last_wr, d, "fab written");
        end
        summarize();
    end
endmodule
`default_nettype wire
